/* rtcca_calendar_alarm.sv */
/*
 * Calendar (minute to year) counters, access blocking, and alarm match with
 * its sticky flag and level interrupt output.
 * Assumes the serial bus engine supplies a byte-wide register port with an
 * access-window level, one-cycle write and read strobes and an auto-
 * incrementing address, and that a once-a-minute minute-carry tick comes from the
 * seconds logic, all on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rtcca_calendar_alarm (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register port from the bus engine.
   input  wire logic       acc_active,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data,
   output logic      [7:0] next_addr,
   // Time base and neighbouring control bits.
   input  wire logic       minute_tick,
   input  wire logic       hour_mode_12,
   input  wire logic       alarm_irq_enable,
   input  wire logic [3:0] other_flag_set,
   // Status and interrupt.
   output logic            alarm_flag,
   output logic            irq_output_first_n
);
   // ----------------------------------------------------------------------
   // State registers.
   // ----------------------------------------------------------------------
   rtcca_pkg::rtcca_state_t state_reg;
   rtcca_pkg::rtcca_state_t state_next;
   rtcca_pkg::rtcca_time_t  adv_time;
   logic                    do_adv;
   logic                    match_now;

   // BCD increment with wrap from hi back to lo.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] hi,
                                          input logic [7:0] lo);
      logic [7:0] r;
      r = v;
      if (v == hi) begin
         r = lo;
      end else if (v[3:0] == 4'h9) begin
         r = {v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction : bcd_inc

   // Last day of the month in BCD; the leap test on BCD year: tens even needs
   // units in 0,4,8, tens odd needs units 2 or 6.
   function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      logic [7:0] r;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         8'h02:   r = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
         default: r = 8'h31;
      endcase
      return r;
   endfunction : last_day

   // ----------------------------------------------------------------------
   // Calendar advance by one minute, including 12 hour rollover.
   // ----------------------------------------------------------------------
   always_comb begin
      logic day_carry;
      day_carry = 1'b0;
      adv_time  = state_reg.time_val;
      adv_time.minute = bcd_inc(state_reg.time_val.minute, 8'h59, 8'h00);
      if (state_reg.time_val.minute == 8'h59) begin
         if (hour_mode_12) begin
            // 11 PM to 12 AM carries the day; 11 AM to 12 PM flips the half.
            case (state_reg.time_val.hour[4:0])
               5'h12:   adv_time.hour = {state_reg.time_val.hour[7:5], 5'h01};
               5'h11:   begin
                  adv_time.hour = {2'b00, ~state_reg.time_val.hour[5], 5'h12};
                  day_carry     = state_reg.time_val.hour[5];
               end
               default: adv_time.hour = bcd_inc(state_reg.time_val.hour, 8'hff, 8'h00);
            endcase
         end else begin
            adv_time.hour = bcd_inc(state_reg.time_val.hour, 8'h23, 8'h00);
            day_carry     = (state_reg.time_val.hour == 8'h23);
         end
      end
      if (day_carry) begin
         adv_time.weekday = (state_reg.time_val.weekday == 8'h06) ? 8'h00
                            : state_reg.time_val.weekday + 8'h01;
         adv_time.day = bcd_inc(state_reg.time_val.day,
                                last_day(state_reg.time_val.month, state_reg.time_val.year),
                                8'h01);
         if (state_reg.time_val.day == last_day(state_reg.time_val.month,
                                                state_reg.time_val.year)) begin
            adv_time.month = bcd_inc(state_reg.time_val.month, 8'h12, 8'h01);
            if (state_reg.time_val.month == 8'h12) begin
               adv_time.year = bcd_inc(state_reg.time_val.year, 8'h99, 8'h00);
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Alarm comparison against the live counters; disabled fields pass.
   // ----------------------------------------------------------------------
   always_comb begin
      logic hr_eq;
      hr_eq = hour_mode_12
              ? (state_reg.al_hour[5:0] == state_reg.time_val.hour[5:0])
              : (state_reg.al_hour[5:0] == state_reg.time_val.hour[5:0]);
      match_now = (state_reg.al_minute[rtcca_pkg::RTCCA_BIT_DISABLE] ||
                   state_reg.al_minute[6:0] == state_reg.time_val.minute[6:0]) &&
                  (state_reg.al_hour[rtcca_pkg::RTCCA_BIT_DISABLE] || hr_eq) &&
                  (state_reg.al_day[rtcca_pkg::RTCCA_BIT_DISABLE] ||
                   state_reg.al_day[5:0] == state_reg.time_val.day[5:0]) &&
                  (state_reg.al_wday[rtcca_pkg::RTCCA_BIT_DISABLE] ||
                   state_reg.al_wday[2:0] == state_reg.time_val.weekday[2:0]) &&
                  !(state_reg.al_minute[rtcca_pkg::RTCCA_BIT_DISABLE] &&
                    state_reg.al_hour[rtcca_pkg::RTCCA_BIT_DISABLE] &&
                    state_reg.al_day[rtcca_pkg::RTCCA_BIT_DISABLE] &&
                    state_reg.al_wday[rtcca_pkg::RTCCA_BIT_DISABLE]);
   end

   // ----------------------------------------------------------------------
   // Next-state logic: access blocking, register writes, flags.
   // A tick during an access is parked in one pending bit; a second tick in
   // the same access is lost, which is why accesses must stay short.
   // ----------------------------------------------------------------------
   always_comb begin
      logic clr_alarm;
      clr_alarm  = 1'b0;
      state_next = state_reg;
      do_adv     = 1'b0;
      case (state_reg.acc)
         rtcca_pkg::RTCCA_IDLE: begin
            if (acc_active) begin
               state_next.acc = rtcca_pkg::RTCCA_BUSY;
            end
         end
         rtcca_pkg::RTCCA_BUSY: begin
            if (!acc_active) begin
               state_next.acc = rtcca_pkg::RTCCA_RELEASE;
            end
         end
         rtcca_pkg::RTCCA_RELEASE: begin
            state_next.acc = acc_active ? rtcca_pkg::RTCCA_BUSY : rtcca_pkg::RTCCA_IDLE;
         end
         default: state_next.acc = rtcca_pkg::RTCCA_IDLE;
      endcase
      if (acc_active) begin
         if (minute_tick) begin
            state_next.pending = 1'b1;
         end
      end else if (minute_tick || state_reg.pending) begin
         do_adv             = 1'b1;
         state_next.pending = 1'b0;
         state_next.time_val = adv_time;
      end
      // Register writes are only taken inside the access window.
      if (wr_stb && acc_active) begin
         case (reg_addr)
            rtcca_pkg::RTCCA_ADDR_MINUTE:    state_next.time_val.minute  = {1'b0, wr_data[6:0]};
            rtcca_pkg::RTCCA_ADDR_HOUR:      state_next.time_val.hour    = {2'b00, wr_data[5:0]};
            rtcca_pkg::RTCCA_ADDR_DAY:       state_next.time_val.day     = {2'b00, wr_data[5:0]};
            rtcca_pkg::RTCCA_ADDR_WEEKDAY:   state_next.time_val.weekday = {5'h00, wr_data[2:0]};
            rtcca_pkg::RTCCA_ADDR_MONTH:     state_next.time_val.month   = {3'h0, wr_data[4:0]};
            rtcca_pkg::RTCCA_ADDR_YEAR:      state_next.time_val.year    = wr_data;
            rtcca_pkg::RTCCA_ADDR_AL_MINUTE: state_next.al_minute = wr_data;
            rtcca_pkg::RTCCA_ADDR_AL_HOUR:   state_next.al_hour   = {wr_data[7], 1'b0, wr_data[5:0]};
            rtcca_pkg::RTCCA_ADDR_AL_DAY:    state_next.al_day    = {wr_data[7], 1'b0, wr_data[5:0]};
            rtcca_pkg::RTCCA_ADDR_AL_WDAY:   state_next.al_wday   = {wr_data[7], 4'h0, wr_data[2:0]};
            rtcca_pkg::RTCCA_ADDR_FLAGS: begin
               state_next.flags = state_reg.flags & wr_data & rtcca_pkg::RTCCA_FLAG_MASK;
               clr_alarm = ~wr_data[rtcca_pkg::RTCCA_BIT_ALARMF];
            end
            default: ;
         endcase
      end
      // Hardware sets win over a same-cycle clear.
      state_next.flags[7:4] = state_next.flags[7:4] | other_flag_set;
      state_next.match_prev = match_now;
      if (match_now && !state_reg.match_prev) begin
         state_next.flags[rtcca_pkg::RTCCA_BIT_ALARMF] = 1'b1;
      end else if (clr_alarm) begin
         state_next.flags[rtcca_pkg::RTCCA_BIT_ALARMF] = 1'b0;
      end
      // Read data is captured on the strobe so it stays stable for the engine.
      if (rd_stb) begin
         case (reg_addr)
            rtcca_pkg::RTCCA_ADDR_MINUTE:    state_next.rdata = state_reg.time_val.minute;
            rtcca_pkg::RTCCA_ADDR_HOUR:      state_next.rdata = state_reg.time_val.hour;
            rtcca_pkg::RTCCA_ADDR_DAY:       state_next.rdata = state_reg.time_val.day;
            rtcca_pkg::RTCCA_ADDR_WEEKDAY:   state_next.rdata = state_reg.time_val.weekday;
            rtcca_pkg::RTCCA_ADDR_MONTH:     state_next.rdata = state_reg.time_val.month;
            rtcca_pkg::RTCCA_ADDR_YEAR:      state_next.rdata = state_reg.time_val.year;
            rtcca_pkg::RTCCA_ADDR_AL_MINUTE: state_next.rdata = state_reg.al_minute;
            rtcca_pkg::RTCCA_ADDR_AL_HOUR:   state_next.rdata = state_reg.al_hour;
            rtcca_pkg::RTCCA_ADDR_AL_DAY:    state_next.rdata = state_reg.al_day;
            rtcca_pkg::RTCCA_ADDR_AL_WDAY:   state_next.rdata = state_reg.al_wday;
            rtcca_pkg::RTCCA_ADDR_FLAGS:     state_next.rdata = state_reg.flags;
            default:                         state_next.rdata = rtcca_pkg::RTCCA_RST_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.time_val.minute  <= rtcca_pkg::RTCCA_RST_ZERO;
         state_reg.time_val.hour    <= rtcca_pkg::RTCCA_RST_HOUR;
         state_reg.time_val.day     <= rtcca_pkg::RTCCA_RST_DAY;
         state_reg.time_val.weekday <= rtcca_pkg::RTCCA_RST_ZERO;
         state_reg.time_val.month   <= rtcca_pkg::RTCCA_RST_MONTH;
         state_reg.time_val.year    <= rtcca_pkg::RTCCA_RST_ZERO;
         state_reg.al_minute        <= rtcca_pkg::RTCCA_RST_ALARM;
         state_reg.al_hour          <= rtcca_pkg::RTCCA_RST_ALARM;
         state_reg.al_day           <= rtcca_pkg::RTCCA_RST_ALARM;
         state_reg.al_wday          <= rtcca_pkg::RTCCA_RST_ALARM;
         state_reg.flags            <= rtcca_pkg::RTCCA_RST_ZERO;
         state_reg.pending          <= 1'b0;
         state_reg.match_prev       <= 1'b0;
         state_reg.acc              <= rtcca_pkg::RTCCA_IDLE;
         state_reg.rdata            <= rtcca_pkg::RTCCA_RST_ZERO;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs. The interrupt is a pure level of flag and enable, so a clear
   // drops it in the same cycle the flag falls.
   // ----------------------------------------------------------------------
   assign rd_data            = state_reg.rdata;
   assign next_addr          = reg_addr + 8'h01;
   assign alarm_flag         = state_reg.flags[rtcca_pkg::RTCCA_BIT_ALARMF];
   assign irq_output_first_n = ~(alarm_irq_enable &&
                                 state_reg.flags[rtcca_pkg::RTCCA_BIT_ALARMF]);
endmodule : rtcca_calendar_alarm
`default_nettype wire

/* rtcca_calendar_alarm_chk.sv */
/* Checker for the calendar and alarm block: flag, interrupt and read-port relations.
   Assumes it is bound to the top module and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module rtcca_calendar_alarm_chk (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       rst_n,
   // Register port.
   input wire logic       acc_active,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] next_addr,
   // Time base and control.
   input wire logic       minute_tick,
   input wire logic       hour_mode_12,
   input wire logic       alarm_irq_enable,
   input wire logic [3:0] other_flag_set,
   // Status.
   input wire logic       alarm_flag,
   input wire logic       irq_output_first_n
);
   // ---------------------------------------------------------------
   // Port relations.
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // A flag clear inside an access cannot meet a fresh match, so it must win.
   logic flag_clr;
   assign flag_clr = wr_stb && acc_active && reg_addr == rtcca_pkg::RTCCA_ADDR_FLAGS
                     && !wr_data[rtcca_pkg::RTCCA_BIT_ALARMF];
   irq_level_a: assert property (irq_output_first_n == !(alarm_irq_enable && alarm_flag))
      else $error("interrupt output does not follow the flag");
   flag_clear_a: assert property (flag_clr |=> !alarm_flag)
      else $error("alarm flag not cleared by write");
   flag_hold_a: assert property (alarm_flag && !flag_clr |=> alarm_flag)
      else $error("alarm flag dropped without clear");
   flag_bits_a: assert property (rd_stb && reg_addr == rtcca_pkg::RTCCA_ADDR_FLAGS
      |=> rd_data[2:0] == 3'h0 && rd_data[3] == $past(alarm_flag))
      else $error("flag register read wrong");
   month_code_a: assert property (rd_stb && reg_addr == rtcca_pkg::RTCCA_ADDR_MONTH
      |=> rd_data inside {[8'h01:8'h09], [8'h10:8'h12]})
      else $error("month not in BCD range");
   year_code_a: assert property (rd_stb && reg_addr == rtcca_pkg::RTCCA_ADDR_YEAR
      |=> rd_data[7:4] <= 4'h9 && rd_data[3:0] <= 4'h9)
      else $error("year not in BCD range");
   addr_step_a: assert property (next_addr == reg_addr + 8'h01)
      else $error("pointer does not step by one");
   freeze_block_a: assert property ($rose(alarm_flag)
      |-> $past(wr_stb, 2) || !$past(acc_active, 2))
      else $error("time advanced inside an access");
   cover property ($rose(alarm_flag) && alarm_irq_enable);
   cover property (flag_clr && alarm_flag);
   cover property ($fell(acc_active));
endmodule : rtcca_calendar_alarm_chk
`default_nettype wire

/* rtcca_host_model.sv */
/* Host model: drives the byte-wide register port as the bus engine would.
   Assumes the testbench calls its tasks and that one clock serves both sides. */
`timescale 1ns/1ps
`default_nettype none
module rtcca_host_model (
   // Clock.
   input  wire logic       clk,
   // Register port towards the block.
   output logic            acc_active,
   output logic            wr_stb,
   output logic            rd_stb,
   output logic      [7:0] reg_addr,
   output logic      [7:0] wr_data,
   input  wire logic [7:0] rd_data,
   input  wire logic [7:0] next_addr
);
   // ---------------------------------------------------------------
   // Access tasks, all changes at the falling edge.
   // ---------------------------------------------------------------
   initial begin
      {acc_active, wr_stb, rd_stb} = 3'h0;
      {reg_addr, wr_data} = 16'h0000;
   end
   // Opens an access, or moves the pointer inside an open one.
   task automatic open_acc(input logic [7:0] addr);
      @(negedge clk);
      acc_active = 1'b1;
      reg_addr = addr;
   endtask : open_acc
   task automatic put_byte(input logic [7:0] data);
      @(negedge clk);
      wr_stb = 1'b1;
      wr_data = data;
      @(negedge clk);
      wr_stb = 1'b0;
      wr_data = ~data; // An idle data bus must not look like the last byte.
      reg_addr = next_addr;
   endtask : put_byte
   task automatic get_byte(output logic [7:0] data);
      @(negedge clk);
      rd_stb = 1'b1;
      @(negedge clk);
      rd_stb = 1'b0;
      data = rd_data;
      reg_addr = next_addr;
   endtask : get_byte
   // Accesses last a few cycles, far below one second of time base.
   task automatic close_acc();
      @(negedge clk);
      acc_active = 1'b0;
      reg_addr = ~reg_addr;
   endtask : close_acc
endmodule : rtcca_host_model
`default_nettype wire

/* rtcca_pkg.sv */
/*
 * Package for the calendar and alarm block: register indices, field positions,
 * reset values, the access state encoding and the carrier structs.
 * Assumes a single 10 MHz clock domain and an asynchronous active-low reset.
 */
`default_nettype none
package rtcca_pkg;
   // ----------------------------------------------------------------------
   // Register indices.
   // ----------------------------------------------------------------------
   localparam logic [7:0] RTCCA_ADDR_MINUTE    = 8'h04;
   localparam logic [7:0] RTCCA_ADDR_HOUR      = 8'h05;
   localparam logic [7:0] RTCCA_ADDR_DAY       = 8'h06;
   localparam logic [7:0] RTCCA_ADDR_WEEKDAY   = 8'h07;
   localparam logic [7:0] RTCCA_ADDR_MONTH     = 8'h08;
   localparam logic [7:0] RTCCA_ADDR_YEAR      = 8'h09;
   localparam logic [7:0] RTCCA_ADDR_AL_MINUTE = 8'h0a;
   localparam logic [7:0] RTCCA_ADDR_AL_HOUR   = 8'h0b;
   localparam logic [7:0] RTCCA_ADDR_AL_DAY    = 8'h0c;
   localparam logic [7:0] RTCCA_ADDR_AL_WDAY   = 8'h0d;
   localparam logic [7:0] RTCCA_ADDR_FLAGS     = 8'h01;
   // ----------------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------------
   localparam int RTCCA_BIT_DISABLE = 7;
   localparam int RTCCA_BIT_PM      = 5;
   localparam int RTCCA_BIT_ALARMF  = 3;
   // ----------------------------------------------------------------------
   // Reset values and the flag write mask.
   // ----------------------------------------------------------------------
   localparam logic [7:0] RTCCA_RST_ALARM = 8'h80;
   localparam logic [7:0] RTCCA_RST_MONTH = 8'h01;
   localparam logic [7:0] RTCCA_RST_DAY   = 8'h01;
   localparam logic [7:0] RTCCA_RST_HOUR  = 8'h00;
   localparam logic [7:0] RTCCA_RST_ZERO  = 8'h00;
   localparam logic [7:0] RTCCA_FLAG_MASK = 8'hf8;
   // ----------------------------------------------------------------------
   // Access state, Gray coded along idle, busy, release.
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      RTCCA_IDLE    = 2'b00,
      RTCCA_BUSY    = 2'b01,
      RTCCA_RELEASE = 2'b11
   } rtcca_acc_t;
   // ----------------------------------------------------------------------
   // Time counters and full module state.
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] minute;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] weekday;
      logic [7:0] month;
      logic [7:0] year;
   } rtcca_time_t;
   typedef struct packed {
      rtcca_time_t time_val;
      logic [7:0]  al_minute;
      logic [7:0]  al_hour;
      logic [7:0]  al_day;
      logic [7:0]  al_wday;
      logic [7:0]  flags;
      logic        pending;
      logic        match_prev;
      rtcca_acc_t  acc;
      logic [7:0]  rdata;
   } rtcca_state_t;
endpackage : rtcca_pkg
`default_nettype wire

/* test_rtc_calendar_alarm.sv */
/* Testbench for the calendar and alarm block with the host model and bound checker.
   Assumes a 10 MHz clock; the minute tick is driven directly by the bench. */
`timescale 1ns/1ps
`default_nettype none
module test_rtc_calendar_alarm;
   localparam logic [7:0] FLAGS_IX = rtcca_pkg::RTCCA_ADDR_FLAGS;
   localparam logic [7:0] MIN_IX   = rtcca_pkg::RTCCA_ADDR_MINUTE;
   logic       clk = 1'b0;
   logic       rst_n, acc_active, wr_stb, rd_stb, minute_tick, hour_mode_12, alarm_irq_enable;
   logic       alarm_flag, irq_output_first_n;
   logic [7:0] reg_addr, wr_data, rd_data, next_addr, got;
   logic [3:0] other_flag_set;
   logic [7:0]  yr_tab [3] = '{8'h00, 8'h04, 8'h01};
   logic [15:0] dm_tab [3] = '{16'h2902, 16'h2902, 16'h0103};
   int         mismatches = 0;
   int         comparisons = 0;
   always #50 clk = ~clk;
   rtcca_calendar_alarm dut_u (.clk(clk), .rst_n(rst_n), .acc_active(acc_active),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr), .wr_data(wr_data),
      .rd_data(rd_data), .next_addr(next_addr), .minute_tick(minute_tick),
      .hour_mode_12(hour_mode_12), .alarm_irq_enable(alarm_irq_enable),
      .other_flag_set(other_flag_set), .alarm_flag(alarm_flag),
      .irq_output_first_n(irq_output_first_n));
   rtcca_host_model host_u (.clk(clk), .acc_active(acc_active), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
      .next_addr(next_addr));
   // ---------------------------------------------------------------
   // Compare, access and closing tasks.
   // ---------------------------------------------------------------
   task automatic chk8(input logic [7:0] got_v, input logic [7:0] exp_v);
      comparisons++;
      if (got_v !== exp_v) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask : chk8
   task automatic wr1(input logic [7:0] addr, input logic [7:0] data);
      host_u.open_acc(addr);
      host_u.put_byte(data);
      host_u.close_acc();
   endtask : wr1
   task automatic rd1(input logic [7:0] addr, input logic [7:0] exp_v);
      logic [7:0] v;
      host_u.open_acc(addr);
      host_u.get_byte(v);
      host_u.close_acc();
      chk8(v, exp_v);
   endtask : rd1
   // Writes n bytes from the minute index upwards and leaves the access open.
   task automatic load(input logic [79:0] v, input int n);
      host_u.open_acc(MIN_IX);
      for (int i = 0; i < n; i++) begin
         host_u.put_byte(v[79 - 8 * i -: 8]);
      end
   endtask : load
   task automatic tick();
      @(negedge clk);
      minute_tick = 1'b1;
      @(negedge clk);
      minute_tick = 1'b0;
      repeat (2) @(negedge clk);
   endtask : tick
   // Reads minute to year in one access, as a real host must.
   task automatic check_time(input logic [47:0] t);
      logic [7:0] v;
      host_u.open_acc(MIN_IX);
      for (int i = 0; i < 6; i++) begin
         host_u.get_byte(v);
         chk8(v, t[47 - 8 * i -: 8]);
      end
      host_u.close_acc();
   endtask : check_time
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   // Hang guard: a run that overstays counts as a failure.
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      summarize();
   end
   // Main sequence.
   initial begin
      {rst_n, minute_tick, hour_mode_12, alarm_irq_enable, other_flag_set} = 8'h00;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      rd1(rtcca_pkg::RTCCA_ADDR_MONTH, 8'h01);
      rd1(rtcca_pkg::RTCCA_ADDR_YEAR, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rd1(8'h0a + i[7:0], 8'h80);
      end
      wr1(8'h0e, 8'h55);
      rd1(8'h0e, 8'h00);
      // Full rollover with all alarm fields disabled leaves the flag clear.
      load(80'h59_23_31_06_12_99_0000_0000, 6);
      host_u.close_acc();
      tick();
      check_time(48'h00_00_01_00_01_00);
      chk8({7'h00, alarm_flag}, 8'h00);
      for (int i = 0; i < 3; i++) begin
         load({32'h59_23_28_03, 8'h02, yr_tab[i], 32'h0}, 6);
         host_u.close_acc();
         tick();
         check_time({16'h0000, dm_tab[i][15:8], 8'h04, dm_tab[i][7:0], yr_tab[i]});
      end
      hour_mode_12 = 1'b1;
      load(80'h59_31_15_02_05_20_0000_0000, 6);
      host_u.close_acc();
      tick();
      check_time(48'h00_12_16_03_05_20);
      hour_mode_12 = 1'b0;
      // All four alarm fields armed in the same access as the time.
      load(80'h59_23_31_06_12_99_00_00_01_00, 10);
      host_u.close_acc();
      tick();
      chk8({7'h00, alarm_flag}, 8'h01);
      chk8({7'h00, irq_output_first_n}, 8'h01);
      alarm_irq_enable = 1'b1;
      @(negedge clk);
      chk8({7'h00, irq_output_first_n}, 8'h00);
      rd1(FLAGS_IX, 8'h08);
      wr1(FLAGS_IX, 8'hff);
      chk8({7'h00, alarm_flag}, 8'h01);
      wr1(FLAGS_IX, 8'hf0);
      chk8({7'h00, irq_output_first_n}, 8'h01);
      repeat (5) @(negedge clk);
      chk8({7'h00, alarm_flag}, 8'h00);
      other_flag_set = 4'hf;
      @(negedge clk);
      other_flag_set = 4'h0;
      rd1(FLAGS_IX, 8'hf0);
      wr1(FLAGS_IX, 8'h58);
      rd1(FLAGS_IX, 8'h50);
      // Two ticks inside one access: frozen, then exactly one advance.
      load(80'h59_23_31_06_12_99_0000_0000, 6);
      tick();
      tick();
      host_u.open_acc(MIN_IX);
      host_u.get_byte(got);
      chk8(got, 8'h59);
      host_u.close_acc();
      repeat (3) @(negedge clk);
      check_time(48'h00_00_01_00_01_00);
      chk8({7'h00, alarm_flag}, 8'h01);
      summarize();
   end
endmodule : test_rtc_calendar_alarm
bind rtcca_calendar_alarm rtcca_calendar_alarm_chk chk_u (.clk(clk), .rst_n(rst_n),
   .acc_active(acc_active), .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr),
   .wr_data(wr_data), .rd_data(rd_data), .next_addr(next_addr),
   .minute_tick(minute_tick), .hour_mode_12(hour_mode_12),
   .alarm_irq_enable(alarm_irq_enable), .other_flag_set(other_flag_set),
   .alarm_flag(alarm_flag), .irq_output_first_n(irq_output_first_n));
`default_nettype wire
